// File: logic/fsh_bus_cycle.sv
// drives one timed write or read cycle on the flash pins
`timescale 1ns/100ps
module fsh_bus_cycle (
   input  wire logic                        clock,
   input  wire logic                        rstn,
   fsh_cyc_if.slave                         cyc,
   output logic      [fsh_pkg::ADDR_W-1:0]  flash_addr,
   output logic      [fsh_pkg::DATA_W-1:0]  flash_dq_out,
   input  wire logic [fsh_pkg::DATA_W-1:0]  flash_dq_in,
   output logic                             flash_dq_oe_n,
   output logic                             flash_ce_n,
   output logic                             flash_oe_n,
   output logic                             flash_we_n
);
   typedef enum logic [1:0] {PH_IDLE = 2'b00, PH_ACT = 2'b01, PH_REC = 2'b11} fsh_ph_t;
   fsh_ph_t    phase;
   logic [7:0] cnt;
   logic       is_wr;

   // phase and timing counter
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         phase <= PH_IDLE;
         cnt   <= fsh_pkg::CNT_ZERO;
         is_wr <= 1'b0;
      end else begin
         case (phase)
            PH_IDLE: begin
               if (cyc.req && !cyc.done) begin
                  phase <= PH_ACT;
                  is_wr <= cyc.wr;
                  cnt   <= cyc.wr ? fsh_pkg::T_WP_CYC : fsh_pkg::T_ACC_CYC;
               end
            end
            PH_ACT: begin
               if (cnt == fsh_pkg::CNT_ONE) begin
                  phase <= PH_REC;
                  cnt   <= is_wr ? fsh_pkg::T_WPH_CYC : fsh_pkg::T_REC_CYC;
               end else begin
                  cnt <= cnt - fsh_pkg::CNT_ONE;
               end
            end
            PH_REC: begin
               if (cnt == fsh_pkg::CNT_ONE) begin
                  phase <= PH_IDLE;
               end else begin
                  cnt <= cnt - fsh_pkg::CNT_ONE;
               end
            end
            default: phase <= PH_IDLE;
         endcase
      end
   end

   // pin strobes, data lanes and completion
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         flash_addr    <= fsh_pkg::ADDR_RESET;
         flash_dq_out  <= fsh_pkg::DATA_RESET;
         flash_dq_oe_n <= 1'b1;
         flash_ce_n    <= 1'b1;
         flash_oe_n    <= 1'b1;
         flash_we_n    <= 1'b1;
         cyc.done      <= 1'b0;
         cyc.rdata     <= fsh_pkg::DATA_RESET;
      end else begin
         cyc.done <= 1'b0;
         if (phase == PH_IDLE && cyc.req && !cyc.done) begin
            flash_addr    <= cyc.addr;
            flash_dq_out  <= cyc.wdata;
            flash_dq_oe_n <= !cyc.wr;
            flash_ce_n    <= 1'b0;
            flash_we_n    <= !cyc.wr;
            flash_oe_n    <= cyc.wr;
         end else if (phase == PH_ACT && cnt == fsh_pkg::CNT_ONE) begin
            flash_ce_n <= 1'b1;
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
            if (!is_wr) begin
               cyc.rdata <= flash_dq_in;
            end
         end else if (phase == PH_REC && cnt == fsh_pkg::CNT_ONE) begin
            // data held through recovery so it stays valid past the strobe edge
            flash_dq_oe_n <= 1'b1;
            cyc.done      <= 1'b1;
         end
      end
   end
endmodule

// File: logic/fsh_cyc_if.sv
// one flash bus cycle request between sequencer and pin driver
`timescale 1ns/100ps
interface fsh_cyc_if;
   logic                        req;
   logic                        wr;
   logic [fsh_pkg::ADDR_W-1:0]  addr;
   logic [fsh_pkg::DATA_W-1:0]  wdata;
   logic                        done;
   logic [fsh_pkg::DATA_W-1:0]  rdata;
   modport master (output req, output wr, output addr, output wdata,
                   input done, input rdata);
   modport slave  (input req, input wr, input addr, input wdata,
                   output done, output rdata);
endinterface

// File: logic/fsh_pkg.sv
// constants, register map and types of the flash sequencer host
package fsh_pkg;
   localparam int ADDR_W = 20;
   localparam int DATA_W = 16;
   localparam int PADDR_W = 12;
   // apb register offsets
   localparam logic [PADDR_W-1:0] REG_CTRL   = 12'h000;
   localparam logic [PADDR_W-1:0] REG_ADDR   = 12'h004;
   localparam logic [PADDR_W-1:0] REG_WDATA  = 12'h008;
   localparam logic [PADDR_W-1:0] REG_STATUS = 12'h00c;
   localparam logic [PADDR_W-1:0] REG_RDATA  = 12'h010;
   // register fields
   localparam int CTRL_OP_LSB = 0;
   localparam int CTRL_ALT_BIT = 8;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_SR_LSB = 8;
   localparam int STAT_ERR_LSB = 16;
   localparam int ERR_W = 5;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 20'h00000;
   localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
   localparam logic [7:0] SR_RESET = 8'h00;
   // device command codes
   localparam logic [7:0] CMD_BLOCK_ERASE  = 8'h20;
   localparam logic [7:0] CMD_CHIP_ERASE   = 8'h30;
   localparam logic [7:0] CMD_PROGRAM      = 8'h40;
   localparam logic [7:0] CMD_PROGRAM_ALT  = 8'h10;
   localparam logic [7:0] CMD_CONFIRM      = 8'hd0;
   localparam logic [7:0] CMD_READ_ARRAY   = 8'hff;
   localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] CMD_READ_ID      = 8'h90;
   // operation_status bit positions
   localparam int SR_READY = 7;
   localparam int SR_ERASE_ERR = 5;
   localparam int SR_PROG_ERR = 4;
   localparam int SR_SUPPLY = 3;
   localparam int SR_PROTECT = 1;
   localparam int SR_RESV = 0;
   // error summary positions
   localparam int ERR_SUPPLY = 0;
   localparam int ERR_PROTECT = 1;
   localparam int ERR_SEQ = 2;
   localparam int ERR_ERASE = 3;
   localparam int ERR_PROG = 4;
   // bus timing
   localparam int CLK_NS = 4;
   localparam int T_WP_NS = 50;
   localparam int T_WPH_NS = 30;
   localparam int T_ACC_NS = 90;
   localparam int T_REC_NS = 30;
   localparam logic [7:0] T_WP_CYC  = 8'((T_WP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] T_WPH_CYC = 8'((T_WPH_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] T_ACC_CYC = 8'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] T_REC_CYC = 8'((T_REC_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0] CNT_ONE = 8'h01;
   localparam logic [7:0] CNT_ZERO = 8'h00;
   typedef enum logic [2:0] {
      OP_READ        = 3'h0,
      OP_BLOCK_ERASE = 3'h1,
      OP_CHIP_ERASE  = 3'h2,
      OP_PROGRAM     = 3'h3,
      OP_CLEAR       = 3'h4,
      OP_READ_ARRAY  = 3'h5,
      OP_READ_STATUS = 3'h6,
      OP_READ_ID     = 3'h7
   } fsh_op_t;
endpackage

// File: logic/fsh_seq_host.sv
// apb-controlled host sequencer for erase, program and status of a parallel flash
//
// Notes on behaviour
// - Status bit 0 is reserved; the host masks it in polled status but not in RDATA reads.
// - Bits 6 to 0 are meaningful only once bit 7 reads ready.
// - Completion is found from the ready pin or by polling bit 7.
// - Block erase is 20H then D0H at an address inside the block.
// - Chip erase is 30H then D0H, full status checked afterwards.
// - Word or byte write is 40H or 10H then the data to target.
// - After any error the host clears status before retrying.
// - Repeated writes or erases may share one final full status check.
// - Writing FFH returns the device to array read.
// - Writing 70H makes following reads return the status byte.
`timescale 1ns/100ps
module fsh_seq_host (
   input  wire logic                         clock,
   input  wire logic                         rstn,
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [fsh_pkg::PADDR_W-1:0]  paddr,
   input  wire logic [31:0]                  pwdata,
   output logic      [31:0]                  prdata,
   output logic                              pready,
   output logic                              pslverr,
   output logic      [fsh_pkg::ADDR_W-1:0]   flash_addr,
   output logic      [fsh_pkg::DATA_W-1:0]   flash_dq_out,
   input  wire logic [fsh_pkg::DATA_W-1:0]   flash_dq_in,
   output logic                              flash_dq_oe_n,
   output logic                              flash_ce_n,
   output logic                              flash_oe_n,
   output logic                              flash_we_n,
   input  wire logic                         ready_busy_output
);
   typedef enum logic [2:0] {
      S_IDLE     = 3'b000,
      S_PRE_CMD  = 3'b001,
      S_PRE_POLL = 3'b011,
      S_SETUP    = 3'b010,
      S_CONFIRM  = 3'b110,
      S_POLL     = 3'b111,
      S_DONE     = 3'b101
   } fsh_state_t;

   fsh_cyc_if cyc ();

   fsh_state_t                 state;
   fsh_state_t                 next_state;
   fsh_pkg::fsh_op_t           op;
   logic                       alt_setup;
   logic [fsh_pkg::ADDR_W-1:0] addr_reg;
   logic [fsh_pkg::DATA_W-1:0] wdata_reg;
   logic [fsh_pkg::DATA_W-1:0] rdata_reg;
   logic [7:0]                 sr_q;
   logic [7:0]                 last_cmd;
   logic [fsh_pkg::ERR_W-1:0]  err;
   logic [fsh_pkg::ERR_W-1:0]  chk_err;
   logic [7:0]                 sr_in;
   logic                       long_op;
   logic                       start;
   logic                       refuse;
   logic                       acc;
   logic                       issue;
   logic                       next_wr;
   logic [fsh_pkg::DATA_W-1:0] next_wdata;
   logic                       wdone;
   logic                       rdone;

   fsh_bus_cycle u_bus (
      .clock         (clock),
      .rstn          (rstn),
      .cyc           (cyc.slave),
      .flash_addr    (flash_addr),
      .flash_dq_out  (flash_dq_out),
      .flash_dq_in   (flash_dq_in),
      .flash_dq_oe_n (flash_dq_oe_n),
      .flash_ce_n    (flash_ce_n),
      .flash_oe_n    (flash_oe_n),
      .flash_we_n    (flash_we_n)
   );

   assign sr_in = cyc.rdata[7:0] & ~(8'h01 << fsh_pkg::SR_RESV);

   fsh_status_check u_chk (
      .sr  (sr_in),
      .err (chk_err)
   );

   assign long_op = (op == fsh_pkg::OP_BLOCK_ERASE) || (op == fsh_pkg::OP_CHIP_ERASE)
                    || (op == fsh_pkg::OP_PROGRAM);
   assign wdone = cyc.done && cyc.wr;
   assign rdone = cyc.done && !cyc.wr;
   assign acc   = psel && penable && pready;
   assign start = acc && pwrite && !pslverr && (paddr == fsh_pkg::REG_CTRL);

   // no new erase or write while an error is pending
   always_comb begin
      refuse = 1'b0;
      if (pwrite && paddr == fsh_pkg::REG_CTRL) begin
         refuse = (state != S_IDLE) || ((err != '0) &&
                  (pwdata[2:0] == fsh_pkg::OP_BLOCK_ERASE ||
                   pwdata[2:0] == fsh_pkg::OP_CHIP_ERASE ||
                   pwdata[2:0] == fsh_pkg::OP_PROGRAM));
      end
   end

   // apb slave: one wait-free access phase
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= 1'b0;
         prdata  <= '0;
         if (psel && !penable) begin
            case (paddr)
               fsh_pkg::REG_CTRL: begin
                  prdata[2:0] <= op;
                  prdata[fsh_pkg::CTRL_ALT_BIT] <= alt_setup;
                  pslverr <= refuse;
               end
               fsh_pkg::REG_ADDR:  prdata[fsh_pkg::ADDR_W-1:0] <= addr_reg;
               fsh_pkg::REG_WDATA: prdata[fsh_pkg::DATA_W-1:0] <= wdata_reg;
               fsh_pkg::REG_STATUS: begin
                  prdata[fsh_pkg::STAT_BUSY_BIT] <= (state != S_IDLE);
                  prdata[fsh_pkg::STAT_SR_LSB +: 8] <= sr_q;
                  prdata[fsh_pkg::STAT_ERR_LSB +: fsh_pkg::ERR_W] <= err;
               end
               fsh_pkg::REG_RDATA: prdata[fsh_pkg::DATA_W-1:0] <= rdata_reg;
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end

   // software-written operands
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         op        <= fsh_pkg::OP_READ;
         alt_setup <= 1'b0;
         addr_reg  <= fsh_pkg::ADDR_RESET;
         wdata_reg <= fsh_pkg::DATA_RESET;
      end else if (acc && pwrite && !pslverr) begin
         if (paddr == fsh_pkg::REG_CTRL) begin
            op        <= fsh_pkg::fsh_op_t'(pwdata[fsh_pkg::CTRL_OP_LSB +: 3]);
            alt_setup <= pwdata[fsh_pkg::CTRL_ALT_BIT];
         end
         if (paddr == fsh_pkg::REG_ADDR) begin
            addr_reg <= pwdata[fsh_pkg::ADDR_W-1:0];
         end
         if (paddr == fsh_pkg::REG_WDATA) begin
            wdata_reg <= pwdata[fsh_pkg::DATA_W-1:0];
         end
      end
   end

   // sequence of bus cycles per operation
   always_comb begin
      next_state = state;
      case (state)
         S_IDLE: begin
            if (start) begin
               next_state = (pwdata[2:0] == fsh_pkg::OP_BLOCK_ERASE ||
                             pwdata[2:0] == fsh_pkg::OP_CHIP_ERASE ||
                             pwdata[2:0] == fsh_pkg::OP_PROGRAM) ? S_PRE_CMD : S_SETUP;
            end
         end
         S_PRE_CMD:  if (wdone) next_state = S_PRE_POLL;
         S_PRE_POLL: if (rdone && sr_in[fsh_pkg::SR_READY]) next_state = S_SETUP;
         S_SETUP: begin
            if (cyc.done) begin
               next_state = long_op ? S_CONFIRM : S_DONE;
            end
         end
         S_CONFIRM:  if (wdone) next_state = S_POLL;
         S_POLL:     if (rdone && sr_in[fsh_pkg::SR_READY]) next_state = S_DONE;
         S_DONE:     next_state = S_IDLE;
         default:    next_state = S_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state <= S_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // cycle kind and data for the current state
   always_comb begin
      issue      = 1'b0;
      next_wr    = 1'b1;
      next_wdata = fsh_pkg::DATA_RESET;
      case (state)
         // read-status command before the ready check
         S_PRE_CMD: begin
            issue = 1'b1;
            next_wdata[7:0] = fsh_pkg::CMD_READ_STATUS;
         end
         // next status read only once the ready pin is high
         S_PRE_POLL, S_POLL: begin
            issue   = ready_busy_output;
            next_wr = 1'b0;
         end
         S_SETUP: begin
            issue = 1'b1;
            case (op)
               fsh_pkg::OP_BLOCK_ERASE: next_wdata[7:0] = fsh_pkg::CMD_BLOCK_ERASE;
               fsh_pkg::OP_CHIP_ERASE:  next_wdata[7:0] = fsh_pkg::CMD_CHIP_ERASE;
               fsh_pkg::OP_PROGRAM: next_wdata[7:0] = alt_setup ? fsh_pkg::CMD_PROGRAM_ALT
                                                                 : fsh_pkg::CMD_PROGRAM;
               fsh_pkg::OP_CLEAR:       next_wdata[7:0] = fsh_pkg::CMD_CLEAR_STATUS;
               fsh_pkg::OP_READ_ARRAY:  next_wdata[7:0] = fsh_pkg::CMD_READ_ARRAY;
               fsh_pkg::OP_READ_STATUS: next_wdata[7:0] = fsh_pkg::CMD_READ_STATUS;
               fsh_pkg::OP_READ_ID:     next_wdata[7:0] = fsh_pkg::CMD_READ_ID;
               default:                 next_wr = 1'b0;
            endcase
         end
         S_CONFIRM: begin
            issue = 1'b1;
            if (op == fsh_pkg::OP_PROGRAM) begin
               next_wdata = wdata_reg;
            end else begin
               next_wdata[7:0] = fsh_pkg::CMD_CONFIRM;
            end
         end
         default: issue = 1'b0;
      endcase
   end

   // request to the pin driver, held until done
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cyc.req   <= 1'b0;
         cyc.wr    <= 1'b0;
         cyc.addr  <= fsh_pkg::ADDR_RESET;
         cyc.wdata <= fsh_pkg::DATA_RESET;
      end else if (cyc.done) begin
         cyc.req <= 1'b0;
      end else if (!cyc.req && issue) begin
         cyc.req   <= 1'b1;
         cyc.wr    <= next_wr;
         cyc.addr  <= addr_reg;
         cyc.wdata <= next_wdata;
      end
   end

   // captured status, read data and last command
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         sr_q      <= fsh_pkg::SR_RESET;
         rdata_reg <= fsh_pkg::DATA_RESET;
         last_cmd  <= fsh_pkg::SR_RESET;
      end else begin
         if (rdone && (state == S_PRE_POLL || state == S_POLL)) begin
            sr_q <= sr_in;
         end
         if (rdone && state == S_SETUP) begin
            rdata_reg <= cyc.rdata;
         end
         if (wdone) begin
            last_cmd <= cyc.wdata[7:0];
         end
      end
   end

   // error summary taken only from a ready status byte
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         err <= '0;
      end else if (state == S_DONE && op == fsh_pkg::OP_CLEAR) begin
         err <= '0;
      end else if (rdone && state == S_POLL && sr_in[fsh_pkg::SR_READY]) begin
         err <= err | chk_err;
      end
   end

   // state qualifies the code so program data bytes never look like commands
   sequence wr_of(fsh_state_t st, logic [7:0] code);
      wdone && state == st && cyc.wdata[7:0] == code;
   endsequence

   chk_erase_confirm: assert property (@(posedge clock) disable iff (!rstn)
      wr_of(S_SETUP, fsh_pkg::CMD_BLOCK_ERASE)
      |-> ##[1:60] wr_of(S_CONFIRM, fsh_pkg::CMD_CONFIRM))
      else $error("block erase setup not confirmed");
   chk_chip_confirm: assert property (@(posedge clock) disable iff (!rstn)
      wr_of(S_SETUP, fsh_pkg::CMD_CHIP_ERASE)
      |-> ##[1:60] wr_of(S_CONFIRM, fsh_pkg::CMD_CONFIRM))
      else $error("chip erase setup not confirmed");
   chk_prog_data: assert property (@(posedge clock) disable iff (!rstn)
      (state == S_SETUP && wdone && op == fsh_pkg::OP_PROGRAM)
      |-> ##[1:60] (wdone && cyc.wdata == wdata_reg && cyc.addr == addr_reg))
      else $error("program data write missing");
   chk_done_ready: assert property (@(posedge clock) disable iff (!rstn)
      (state == S_DONE && long_op) |-> sr_q[fsh_pkg::SR_READY])
      else $error("operation ended without ready status");
   chk_err_valid: assert property (@(posedge clock) disable iff (!rstn)
      (err != $past(err) && $past(err) == '0 && !$past(state == S_DONE))
      |-> $past(sr_in[fsh_pkg::SR_READY]) && $past(rdone))
      else $error("errors taken from busy status");
   chk_resv_mask: assert property (@(posedge clock) disable iff (!rstn)
      $past(rdone) |-> !sr_q[fsh_pkg::SR_RESV])
      else $error("reserved status bit not masked");
   chk_status_mode: assert property (@(posedge clock) disable iff (!rstn)
      $rose(state == S_PRE_POLL) |-> last_cmd == fsh_pkg::CMD_READ_STATUS)
      else $error("status polled without read-status command");
   chk_array_exit: assert property (@(posedge clock) disable iff (!rstn)
      (state == S_DONE && op == fsh_pkg::OP_READ_ARRAY)
      |-> last_cmd == fsh_pkg::CMD_READ_ARRAY)
      else $error("read array op did not write FFH");
   chk_retry_block: assert property (@(posedge clock) disable iff (!rstn)
      (state == S_IDLE && err != '0 && start) |=> !long_op)
      else $error("erase or write started with errors pending");
endmodule

// File: logic/fsh_status_check.sv
// decodes a ready operation_status byte into error summary flags
`timescale 1ns/100ps
module fsh_status_check (
   input  wire logic [7:0]                sr,
   output logic      [fsh_pkg::ERR_W-1:0] err
);
   always_comb begin
      err = '0;
      err[fsh_pkg::ERR_SUPPLY]  = sr[fsh_pkg::SR_SUPPLY];
      err[fsh_pkg::ERR_PROTECT] = sr[fsh_pkg::SR_PROTECT];
      // both error bits together mean a bad command sequence
      err[fsh_pkg::ERR_SEQ]   = sr[fsh_pkg::SR_ERASE_ERR] & sr[fsh_pkg::SR_PROG_ERR];
      err[fsh_pkg::ERR_ERASE] = sr[fsh_pkg::SR_ERASE_ERR] & ~sr[fsh_pkg::SR_PROG_ERR];
      err[fsh_pkg::ERR_PROG]  = sr[fsh_pkg::SR_PROG_ERR] & ~sr[fsh_pkg::SR_ERASE_ERR];
   end
endmodule

// File: verification/flash_status_and_erase_program_sequencer_bench.sv
// self-checking bench of the flash sequencer host
`timescale 1ns/100ps
module flash_status_and_erase_program_sequencer_bench;
   logic        clock = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd, o;
   logic        pready, pslverr, er, ce_n, oe_n, we_n, rb, doe;
   logic [19:0] fa, a;
   logic [15:0] fdo, fdi, d;
   logic [7:0]  fail = '0, f;
   logic [4:0]  e;
   int          miscompares = 0, cmp_count = 0, cyc = 0;
   logic [31:0] ops [9] = '{32'h3, 32'h103, 32'h1, 32'h2, 32'h3, 32'h1, 32'h2, 32'h3, 32'h1};
   logic [7:0]  fls [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h20, 8'h30, 8'h08, 8'h02};
   fsh_seq_host i_dut (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .flash_addr(fa), .flash_dq_out(fdo), .flash_dq_in(fdi),
      .flash_dq_oe_n(doe), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
      .ready_busy_output(rb));
   fsh_flash_model i_flash (.clock(clock), .addr(fa), .dq(fdo), .dq_in(fdi), .dq_oe_n(doe),
      .ce_n(ce_n),
      .oe_n(oe_n), .we_n(we_n), .fail_bits(fail), .ready_busy_output(rb));
   initial forever #2 clock = ~clock;
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge clock) begin
      cyc++;
      if (cyc == 60000) begin miscompares++; summarize; end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wv);
      psel <= 1'b1; pwrite <= w; paddr <= ad; pwdata <= wv;
      @(posedge clock);
      penable <= 1'b1;
      // answer read mid-cycle, where the registered outputs have settled
      do @(negedge clock); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      @(posedge clock);
      psel <= 1'b0; penable <= 1'b0;
      @(posedge clock);
   endtask
   task automatic run(input logic [31:0] op);
      apb(1'b1, fsh_pkg::REG_CTRL, op);
      do apb(1'b0, fsh_pkg::REG_STATUS, '0); while (rd[fsh_pkg::STAT_BUSY_BIT] !== 1'b0);
   endtask
   initial begin
      void'($urandom(32'h483b1fc7));
      repeat (3) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
      apb(1'b0, 12'h014, '0);
      check(er, 1); check(rd, 0);
      for (int i = 0; i < 9; i++) begin
         a = 20'($urandom); d = 16'($urandom); f = fls[i]; fail <= f;
         apb(1'b1, fsh_pkg::REG_ADDR, 32'(a)); apb(1'b1, fsh_pkg::REG_WDATA, 32'(d));
         apb(1'b1, fsh_pkg::REG_CTRL, ops[i]);
         apb(1'b1, fsh_pkg::REG_CTRL, 32'h5); check(er, 1);
         run(32'h6);
         check(rd[15:8], {1'b1, f[6:1], 1'b0});
         // both error bits mean a bad sequence, not an erase or write error
         e = {f[4] & ~f[5], f[5] & ~f[4], f[5] & f[4], f[1], f[3]};
         check(rd[20:16], e);
         if (f != 0) begin
            apb(1'b1, fsh_pkg::REG_CTRL, 32'h3); check(er, 1);
            run(32'h4); check(rd[20:16], 0);
         end else begin
            run(32'h5); run(32'h0); apb(1'b0, fsh_pkg::REG_RDATA, '0);
            check(rd, (ops[i][1:0] == 2'h3) ? 32'(d) : 32'h0000ffff);
         end
      end
      for (int k = 6; k < 8; k++) begin
         run(32'(k)); apb(1'b1, fsh_pkg::REG_ADDR, 32'(20'($urandom)));
         run(32'h0); apb(1'b0, fsh_pkg::REG_RDATA, '0);
         o = (k == 6) ? 32'h81 : 32'h0;
         check(rd, o);
      end
      summarize;
   end
endmodule

// File: verification/fsh_flash_model.sv
// behavioural flash device with operation_status for the sequencer bench
`timescale 1ns/100ps
module fsh_flash_model #(parameter int BUSY_CYC = 40) (
   input  wire logic        clock,
   input  wire logic [19:0] addr,
   input  wire logic [15:0] dq,
   output logic      [15:0] dq_in,
   input  wire logic        dq_oe_n,
   input  wire logic        ce_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic [7:0]  fail_bits,
   output logic             ready_busy_output
);
   logic [15:0] mem [int];
   logic [7:0]  sr = 8'h81;
   logic [7:0]  setup = 8'h00;
   logic [19:0] wa = '0;
   logic [15:0] wd = '0;
   logic        wp = 1'b0;
   int          mode = 0;
   int          busy = 0;
   initial dq_in = 16'h0000;
   initial ready_busy_output = 1'b1;
   task automatic take(input logic [19:0] a, input logic [15:0] d);
      if (setup != 8'h00) begin
         if (setup == 8'h40 || setup == 8'h10) mem[a] = d;
         else if (d[7:0] == 8'hd0) mem.delete();
         else sr = sr | 8'h30;
         sr = sr | fail_bits;
         sr[7] = 1'b0;
         busy = BUSY_CYC;
         setup = 8'h00;
      end else case (d[7:0])
         8'h20, 8'h30, 8'h40, 8'h10: begin setup = d[7:0]; mode = 1; end
         8'h50: sr = 8'h81;
         8'h70: mode = 1;
         8'h90: mode = 2;
         default: mode = 0;
      endcase
   endtask
   always @(posedge clock) begin
      // data only seen while the host drives the lanes
      if (!we_n && !ce_n && !dq_oe_n) begin wa = addr; wd = dq; wp = 1'b1; end
      else if (wp) begin wp = 1'b0; take(wa, wd); end
      if (busy > 0) begin busy--; if (busy == 0) sr[7] = 1'b1; end
      // ready pin low while busy, launched after the edge
      ready_busy_output <= (busy == 0);
      // junk low bits while busy, reserved bit set
      if (!oe_n && !ce_n && dq_oe_n) dq_in <= (mode == 1) ? {8'h00, sr[7] ? sr : {1'b0, 7'($urandom)}}
         : (mode == 2) ? 16'h0000 : (mem.exists(addr) ? mem[addr] : 16'hffff);
      else dq_in <= ~dq_in;
   end
endmodule
